// ==== hdl/clock_mode_cfg.svh ====
/*
 Constants of the clock-mode and power-save controller: register offsets,
 field positions, reset values and counts.
 Assumes it is included once per compilation unit, before the package.
*/
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_W 4
`define OFS_CLOCK_MODE_CONTROL 4'h0
`define OFS_POWER_CTRL 4'h1
`define OFS_STATUS 4'h2

// ************************************************************
// Clock mode control fields and reset value
// ************************************************************
`define CMC_RESET 8'h40
`define BIT_SLOW_OSC_ENABLE 7
`define BIT_FAST_OSC_ENABLE 6
`define BIT_IDLE_CLOCK_SOURCE 5
`define BIT_CORE_CLOCK_SELECT 4
`define BIT_RESERVED_ZERO 3
`define WINDOW_MSB 2
`define WINDOW_LSB 0
`define CMC_WRITE_MASK 8'hf7

// Upper nibble codes in their only legal order
`define NIB_HIGH_SPEED 4'h4
`define NIB_TO_DUAL 4'hc
`define NIB_DUAL_CLOCK 4'he
`define NIB_TO_LOW 4'hf
`define NIB_LOW_SPEED 4'hb

// ************************************************************
// Power control fields
// ************************************************************
`define BIT_HALT_REQUEST 7
`define BIT_IDLE_REQUEST 6

// ************************************************************
// Counts
// ************************************************************
`define INSTR_DIV 5
`define HALT_ENTRY_PHASE 2
`define WAKE_CYCLES 256
`define WAKE_CNT_W 9
`define RESET_VECTOR 16'h0000

`endif

// ==== hdl/clock_mode_pkg.sv ====
/*
 Types of the clock-mode and power-save controller.
 Assumes clock_mode_cfg.svh supplies the field widths.
*/
`include "clock_mode_cfg.svh"

package clock_mode_pkg;

    typedef enum logic [1:0] {
        MODE_HIGH = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_LOW = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        PH_RUN = 2'b00,
        PH_IDLE = 2'b01,
        PH_HALT = 2'b10,
        PH_WAKE = 2'b11
    } phase_t;

    typedef struct packed {
        logic fast_s1;
        logic fast_s2;
        logic fast_s3;
        logic slow_s1;
        logic slow_s2;
        logic slow_s3;
        logic wake_s1;
        logic wake_s2;
        logic wake_s3;
        logic allow_s1;
        logic allow_s2;
        logic [7:0] ctrl;
        phase_t phase;
        logic halt_pend;
        logic [2:0] div;
        logic [`WAKE_CNT_W-1:0] wcnt;
        logic core_src;
        logic core_ce;
        logic idle_ce;
        logic t2_ce;
        logic instr_ce;
        logic fast_en;
        logic slow_en;
        logic hold;
        logic dev_rst;
        logic [7:0] rdata;
        logic [15:0] vector;
        mode_t mode;
    } state_t;

endpackage

// ==== hdl/clock_mode_ctrl.sv ====
/*
 Clock-mode and power-save controller: mode register with legality check,
 clock-enable routing for core, idle timer and timer two, halt, idle and
 the wake-up restart delay.
 Assumes both oscillators arrive as free-running pin levels slower than a
 quarter of REF_CLK, the wake-up pin already carries the programmed and
 enabled transition as a rising level, and the core obeys the enables.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"

module clock_mode_ctrl
    import clock_mode_pkg::*;
#(
    parameter int INSTR_DIV = `INSTR_DIV,
    parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [`ADDR_W-1:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [7:0] BUS_RDATA,
    input wire logic FAST_OSC_IN,
    input wire logic SLOW_OSC_IN,
    input wire logic WAKE_PIN,
    input wire logic HALT_OPTION,
    input wire logic IDLE_EXIT,
    input wire logic T2_IDLE_RUN,
    output logic FAST_OSC_EN,
    output logic SLOW_OSC_EN,
    output logic CORE_CLK_EN,
    output logic IDLE_TMR_CLK_EN,
    output logic T2_CLK_EN,
    output logic INSTR_CLK_EN,
    output logic [2:0] IDLE_WINDOW,
    output logic TIMERS_HOLD,
    output logic DEV_RESET,
    output logic [15:0] RESTART_VECTOR,
    output logic [1:0] CLOCK_MODE
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (INSTR_DIV < 3 || INSTR_DIV > 8) begin : g_bad_div
            $error("INSTR_DIV must lie in 3..8");
        end
        if (WAKE_CYCLES < 1 || WAKE_CYCLES > 511) begin : g_bad_wake
            $error("WAKE_CYCLES must lie in 1..511");
        end
    endgenerate

    localparam logic [2:0] DIV_LAST = 3'(INSTR_DIV - 1);
    localparam logic [2:0] DIV_MID = 3'(`HALT_ENTRY_PHASE);
    localparam logic [`WAKE_CNT_W-1:0] WAKE_LOAD = `WAKE_CNT_W'(WAKE_CYCLES);
    localparam logic [`WAKE_CNT_W-1:0] WAKE_LAST = `WAKE_CNT_W'(1);

    // Position in the legal sequence; 7 marks an illegal nibble
    function automatic logic [2:0] nib_step(input logic [3:0] nib);
        logic [2:0] s;
        s = 3'h7;
        if (nib == `NIB_HIGH_SPEED) begin
            s = 3'h0;
        end else if (nib == `NIB_TO_DUAL) begin
            s = 3'h1;
        end else if (nib == `NIB_DUAL_CLOCK) begin
            s = 3'h2;
        end else if (nib == `NIB_TO_LOW) begin
            s = 3'h3;
        end else if (nib == `NIB_LOW_SPEED) begin
            s = 3'h4;
        end
        return s;
    endfunction

    state_t q, d;

    logic fast_tick;
    logic slow_tick;
    logic wake_edge;
    logic instr_tick;
    logic wake_tick;
    logic cmc_wr;
    logic pwr_wr;
    logic move_ok;
    logic [2:0] step_now;
    logic [2:0] step_new;
    logic want_slow;
    logic idle_src_tick;
    logic t2_src_tick;
    mode_t mode_now;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;

        // Pin synchronisers; only the second stage onward is examined
        d.fast_s1 = FAST_OSC_IN;
        d.fast_s2 = q.fast_s1;
        d.fast_s3 = q.fast_s2;
        d.slow_s1 = SLOW_OSC_IN;
        d.slow_s2 = q.slow_s1;
        d.slow_s3 = q.slow_s2;
        d.wake_s1 = WAKE_PIN;
        d.wake_s2 = q.wake_s1;
        d.wake_s3 = q.wake_s2;
        d.allow_s1 = HALT_OPTION;
        d.allow_s2 = q.allow_s1;

        fast_tick = q.fast_s2 & ~q.fast_s3;
        slow_tick = q.slow_s2 & ~q.slow_s3;
        wake_edge = q.wake_s2 & ~q.wake_s3;
        instr_tick = fast_tick && (q.div == DIV_LAST);
        // In low speed the slow clock is the instruction clock
        wake_tick = q.core_src ? slow_tick : instr_tick;

        if (fast_tick) begin
            d.div = (q.div == DIV_LAST) ? 3'h0 : q.div + 3'h1;
        end

        // Bit 4 alone means low speed, which also covers the invalid pair
        if (q.ctrl[`BIT_CORE_CLOCK_SELECT]) begin
            mode_now = MODE_LOW;
        end else if (q.ctrl[`BIT_IDLE_CLOCK_SOURCE]) begin
            mode_now = MODE_DUAL;
        end else begin
            mode_now = MODE_HIGH;
        end
        d.mode = mode_now;

        // ************************************************************
        // Register bus
        // ************************************************************
        cmc_wr = BUS_WR && (BUS_ADDR == `OFS_CLOCK_MODE_CONTROL);
        pwr_wr = BUS_WR && (BUS_ADDR == `OFS_POWER_CTRL);
        step_now = nib_step(q.ctrl[7:4]);
        step_new = nib_step(BUS_WDATA[7:4]);
        // Same step or one neighbour; skipping a step loses the core clock
        move_ok = (step_new != 3'h7) && ((step_new == step_now)
            || (step_new == step_now + 3'h1) || (step_now == step_new + 3'h1));

        d.rdata = 8'h00;
        if (BUS_RD) begin
            if (BUS_ADDR == `OFS_CLOCK_MODE_CONTROL) begin
                d.rdata = q.ctrl;
            end else if (BUS_ADDR == `OFS_POWER_CTRL) begin
                d.rdata = {q.halt_pend, 7'h00};
            end else if (BUS_ADDR == `OFS_STATUS) begin
                d.rdata = {1'b0, q.allow_s2, q.core_src, q.phase, 1'b0, q.mode};
            end else begin
                d.rdata = 8'h00;
            end
        end

        d.dev_rst = 1'b0;

        // ************************************************************
        // Power save sequencing
        // ************************************************************
        case (q.phase)
            PH_RUN: begin
                if (pwr_wr && BUS_WDATA[`BIT_IDLE_REQUEST]
                        && !BUS_WDATA[`BIT_HALT_REQUEST]) begin
                    d.phase = PH_IDLE;
                end else if (q.halt_pend && fast_tick && q.div == DIV_MID) begin
                    // Halt lands mid instruction cycle
                    d.phase = PH_HALT;
                    d.halt_pend = 1'b0;
                end
            end
            PH_IDLE: begin
                if (wake_edge || IDLE_EXIT) begin
                    d.phase = PH_RUN;
                end
            end
            PH_HALT: begin
                if (wake_edge) begin
                    d.phase = PH_WAKE;
                    d.wcnt = WAKE_LOAD;
                end
            end
            PH_WAKE: begin
                if (wake_tick) begin
                    if (q.wcnt == WAKE_LAST) begin
                        d.phase = PH_RUN;
                    end else begin
                        d.wcnt = q.wcnt - WAKE_LAST;
                    end
                end
            end
            default: begin
                d.phase = PH_RUN;
            end
        endcase

        // Set after the entry clear so a request on the entry edge survives
        if (pwr_wr && BUS_WDATA[`BIT_HALT_REQUEST] && q.allow_s2) begin
            d.halt_pend = 1'b1;
        end

        // An illegal setting wins over everything and rebuilds high speed
        if (cmc_wr) begin
            if (move_ok) begin
                d.ctrl = BUS_WDATA & `CMC_WRITE_MASK;
            end else begin
                d.dev_rst = 1'b1;
                d.ctrl = `CMC_RESET;
                d.phase = PH_RUN;
                d.halt_pend = 1'b0;
                d.core_src = 1'b0;
                d.vector = `RESET_VECTOR;
            end
        end

        // ************************************************************
        // Clock enable routing
        // ************************************************************
        // Source swaps where neither clock ticks, so no short pulse; an illegal write clears it at once
        want_slow = (mode_now == MODE_LOW);
        if (!d.dev_rst && want_slow != q.core_src && !fast_tick && !slow_tick) begin
            d.core_src = want_slow;
        end

        d.core_ce = (d.phase == PH_RUN) && (q.core_src ? slow_tick : fast_tick);

        idle_src_tick = q.ctrl[`BIT_IDLE_CLOCK_SOURCE] ? slow_tick : fast_tick;
        if (q.phase == PH_RUN || q.phase == PH_IDLE) begin
            d.idle_ce = idle_src_tick;
        end else if (q.phase == PH_WAKE) begin
            d.idle_ce = wake_tick;
        end else begin
            d.idle_ce = 1'b0;
        end

        t2_src_tick = (mode_now == MODE_LOW) ? slow_tick : fast_tick;
        d.t2_ce = t2_src_tick && ((q.phase == PH_RUN)
            || (q.phase == PH_IDLE && T2_IDLE_RUN));

        d.instr_ce = (q.phase == PH_RUN) && wake_tick;
        // Fast oscillator stays off through halt until the wake edge
        d.fast_en = q.ctrl[`BIT_FAST_OSC_ENABLE] && (d.phase != PH_HALT);
        d.slow_en = q.ctrl[`BIT_SLOW_OSC_ENABLE];
        d.hold = (d.phase != PH_RUN);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            q <= '0;
            q.ctrl <= `CMC_RESET;
            q.phase <= PH_RUN;
            q.vector <= `RESET_VECTOR;
            q.fast_en <= 1'b1;
            q.mode <= MODE_HIGH;
        end else begin
            q <= d;
        end
    end

    assign BUS_RDATA = q.rdata;
    assign FAST_OSC_EN = q.fast_en;
    assign SLOW_OSC_EN = q.slow_en;
    assign CORE_CLK_EN = q.core_ce;
    assign IDLE_TMR_CLK_EN = q.idle_ce;
    assign T2_CLK_EN = q.t2_ce;
    assign INSTR_CLK_EN = q.instr_ce;
    assign IDLE_WINDOW = q.ctrl[`WINDOW_MSB:`WINDOW_LSB];
    assign TIMERS_HOLD = q.hold;
    assign DEV_RESET = q.dev_rst;
    assign RESTART_VECTOR = q.vector;
    assign CLOCK_MODE = q.mode;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    illegal_reset_a: assert property (
        (BUS_WR && BUS_ADDR == `OFS_CLOCK_MODE_CONTROL
            && nib_step(BUS_WDATA[7:4]) == 3'h7) |=> DEV_RESET ##1 !DEV_RESET)
        else $error("illegal nibble did not pulse device reset");

    reset_value_a: assert property (
        DEV_RESET |-> (q.ctrl == `CMC_RESET) && (q.phase == PH_RUN))
        else $error("device reset left wrong control value");

    skip_step_a: assert property (
        (BUS_WR && BUS_ADDR == `OFS_CLOCK_MODE_CONTROL && q.ctrl[7:4] == `NIB_LOW_SPEED
            && BUS_WDATA[7:4] == `NIB_HIGH_SPEED) |=> DEV_RESET)
        else $error("direct low to high speed accepted");

    halt_osc_a: assert property (
        (q.phase == PH_HALT) |-> !FAST_OSC_EN && !CORE_CLK_EN ##1 !CORE_CLK_EN)
        else $error("clocks run during halt");

    halt_forbid_a: assert property (
        (!q.allow_s2 && !q.halt_pend) |=> !q.halt_pend)
        else $error("halt request taken while forbidden");

    wake_load_a: assert property (
        (q.phase == PH_HALT && wake_edge && !(BUS_WR && !move_ok))
            |=> (q.phase == PH_WAKE) && (q.wcnt == WAKE_LOAD))
        else $error("wake count not loaded");

    wake_end_a: assert property (
        (q.phase == PH_WAKE && wake_tick && q.wcnt == WAKE_LAST && !cmc_wr)
            |=> q.phase == PH_RUN ##1 !TIMERS_HOLD)
        else $error("wake count end did not resume");

    core_pulse_a: assert property (
        CORE_CLK_EN |=> !CORE_CLK_EN)
        else $error("core clock enable longer than one cycle");

    t2_idle_a: assert property (
        (q.phase == PH_IDLE && !T2_IDLE_RUN) |=> !T2_CLK_EN)
        else $error("timer two runs in idle while disabled");

    low_force_a: assert property (
        (q.ctrl[`BIT_CORE_CLOCK_SELECT] && !DEV_RESET) |=> CLOCK_MODE == MODE_LOW)
        else $error("core select set but mode not low speed");

    core_follow_a: assert property (
        (q.mode == MODE_LOW && !cmc_wr) [*4] |-> q.core_src)
        else $error("core source did not follow select bit");

endmodule

// ==== verif/osc_pair.sv ====
/*
 Two oscillators beside the clock-mode controller, each running only while
 its enable is high.
 Assumes the enables come straight from the controller outputs.
*/
`timescale 1ns/1ps
module osc_pair #(
    parameter int FAST_HALF_NS = 85,
    parameter int SLOW_HALF_NS = 245
) (
    input wire logic fast_en,
    input wire logic slow_en,
    output logic fast_out,
    output logic slow_out
);
    // Periods are not multiples of 20 ns so edges drift against REF_CLK
    initial begin
        fast_out = 1'b0;
        forever begin
            if (fast_en === 1'b1) begin
                #(FAST_HALF_NS) fast_out = ~fast_out;
            end else begin
                fast_out = 1'b0;
                @(fast_en);
            end
        end
    end
    initial begin
        slow_out = 1'b0;
        forever begin
            if (slow_en === 1'b1) begin
                #(SLOW_HALF_NS) slow_out = ~slow_out;
            end else begin
                slow_out = 1'b0;
                @(slow_en);
            end
        end
    end
endmodule

// ==== verif/dual_clock_power_save_control_tb_top.sv ====
/*
 Self-checking bench of the clock-mode controller: register walk, clock
 routing, idle, halt and wake-up, compared with a small integer model.
 Assumes osc_pair supplies both oscillator waveforms.
*/
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"
module dual_clock_power_save_control_tb_top;
    import clock_mode_pkg::*;
    localparam int WAKE_N = 16;
    logic ref_clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, wake_pin = 1'b0;
    logic halt_option = 1'b0, idle_exit = 1'b0, t2_idle_run = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, v;
    logic fast_in, slow_in, fast_en, slow_en, core_en, idle_en, t2_en, instr_en, hold, dev_rst;
    logic [2:0] window;
    logic [15:0] vector;
    logic [1:0] mode;
    logic [31:0] seed = 32'h19;
    int n_fail = 0, total_checks = 0, n_core, n_instr, n_idle, n_t2, ctrl_m, k, n;
    int seq[$] = '{4, 12, 14, 15, 11};
    logic [7:0] walk[8] = '{8'hc5, 8'he5, 8'hfd, 8'hb2, 8'hf3, 8'he6, 8'hc1, 8'h47};

    always #10 ref_clk = ~ref_clk;

    clock_mode_ctrl #(.INSTR_DIV(5), .WAKE_CYCLES(WAKE_N)) dut (
        .REF_CLK(ref_clk), .RST(rst), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
        .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .FAST_OSC_IN(fast_in),
        .SLOW_OSC_IN(slow_in), .WAKE_PIN(wake_pin), .HALT_OPTION(halt_option),
        .IDLE_EXIT(idle_exit), .T2_IDLE_RUN(t2_idle_run), .FAST_OSC_EN(fast_en),
        .SLOW_OSC_EN(slow_en), .CORE_CLK_EN(core_en), .IDLE_TMR_CLK_EN(idle_en),
        .T2_CLK_EN(t2_en), .INSTR_CLK_EN(instr_en), .IDLE_WINDOW(window),
        .TIMERS_HOLD(hold), .DEV_RESET(dev_rst), .RESTART_VECTOR(vector), .CLOCK_MODE(mode)
    );
    osc_pair oscs (.fast_en(fast_en), .slow_en(slow_en), .fast_out(fast_in), .slow_out(slow_in));

    // ************************************************************
    // Model, bus and check tasks
    // ************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Only a repeat or a single neighbouring step in the nibble order is kept
    function automatic bit model_wr(input int d);
        int cur, nxt;
        cur = -9;
        nxt = -9;
        foreach (seq[i]) begin
            if (seq[i] == (ctrl_m >> 4)) cur = i;
            if (seq[i] == (d >> 4)) nxt = i;
        end
        if (nxt < 0 || nxt - cur > 1 || cur - nxt > 1) begin
            ctrl_m = 'h40;
            return 1'b1;
        end
        ctrl_m = d & 'hf7;
        return 1'b0;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g, input int tol);
        total_checks++;
        if (g < e - tol || g > e + tol) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic rs);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        #1 rs = dev_rst;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic step(input logic [7:0] d);
        logic rs;
        logic [7:0] r;
        bit e;
        wr(4'h0, d, rs);
        e = model_wr(d);
        chk("dev_reset", e, rs);
        rd(4'h0, r);
        chk("ctrl", ctrl_m, r);
        chk("mode", (ctrl_m & 'h10) ? 2 : ((ctrl_m & 'h20) ? 1 : 0), mode);
        chk("window", ctrl_m & 7, window);
        chk("osc_en", (ctrl_m >> 6) & 3, {slow_en, fast_en});
    endtask
    task automatic count(input int w);
        n_core = 0;
        n_instr = 0;
        n_idle = 0;
        n_t2 = 0;
        repeat (w) begin
            @(negedge ref_clk);
            n_core += (core_en === 1'b1);
            n_instr += (instr_en === 1'b1);
            n_idle += (idle_en === 1'b1);
            n_t2 += (t2_en === 1'b1);
        end
    endtask
    task automatic wait_hold(input logic h);
        k = 0;
        while (hold !== h && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        chk("timers_hold", h, hold);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        #600_000;
        n_fail++;
        give_verdict();
    end
    initial begin
        logic rs;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        ctrl_m = 'h40;
        rd(4'h0, v);
        chk("ctrl_reset", 8'h40, v);
        chk("reset_state", 4'h4, {slow_en, fast_en, mode});
        foreach (walk[i]) begin
            step(walk[i]);
            repeat (50) @(posedge ref_clk);
            count(850);
            near("core", (ctrl_m & 'h10) ? 35 : 100, n_core, 3);
            near("t2", (ctrl_m & 'h10) ? 35 : 100, n_t2, 3);
            near("idle_tmr", (ctrl_m & 'h20) ? 35 : 100, n_idle, 3);
            near("instr", (ctrl_m & 'h10) ? 35 : 20, n_instr, 3);
        end
        step(8'hb0);
        step(8'h10);
        repeat (40) begin
            seed = xs();
            step(seed[11] ? seed[7:0] : 8'((seq[seed[10:8] % 5] << 4) | seed[3:0]));
        end
        rd(4'h3, v);
        chk("unmapped", 8'h00, v);
        step(8'hc0);
        step(8'he0);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        ctrl_m = 'h40;
        step(8'h40);
        wr(4'h1, 8'h40, rs);
        wait_hold(1'b1);
        @(posedge ref_clk);
        t2_idle_run <= 1'b1;
        count(850);
        near("idle_core", 0, n_core, 0);
        near("idle_t2", 100, n_t2, 3);
        near("idle_tmr", 100, n_idle, 3);
        @(posedge ref_clk);
        t2_idle_run <= 1'b0;
        count(850);
        near("idle_t2_off", 0, n_t2, 1);
        @(posedge ref_clk);
        idle_exit <= 1'b1;
        @(posedge ref_clk);
        idle_exit <= 1'b0;
        wait_hold(1'b0);
        wr(4'h1, 8'h80, rs);
        rd(4'h1, v);
        chk("halt_forbidden", 8'h00, v);
        chk("no_halt", 1'b0, hold);
        @(posedge ref_clk);
        halt_option <= 1'b1;
        repeat (5) @(posedge ref_clk);
        wr(4'h1, 8'h80, rs);
        wait_hold(1'b1);
        repeat (3) @(posedge ref_clk);
        chk("halt_fast_off", 1'b0, fast_en);
        count(200);
        near("halt_core", 0, n_core + n_instr, 0);
        @(posedge ref_clk);
        wake_pin <= 1'b1;
        n = 0;
        for (k = 0; k < 5000 && hold !== 1'b0; k++) begin
            @(negedge ref_clk);
            n += (idle_en === 1'b1);
        end
        near("wake_ticks", WAKE_N, n, 0);
        near("wake_span", WAKE_N * 5 * 170 / 20, k, 60);
        rd(4'h0, v);
        chk("ctrl_kept", ctrl_m, v);
        @(posedge ref_clk);
        wake_pin <= 1'b0;
        wr(4'h1, 8'h80, rs);
        wait_hold(1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk("reset_exit", 3'b010, {hold, fast_en, slow_en});
        chk("vector", `RESET_VECTOR, vector);
        give_verdict();
    end
endmodule
